//--- design/lcps_front.sv
// Functional notes
// RL1: Input valid only from phase 3 through 0
// RL2: Shaped inputs resynchronised to clock phases
// RL3: Long levels become change-marking pulses
// RL4: Two cascaded polarity holds shape each input
// RL5: Feeder emits line pulses every 14 ms
// RL6: One timing pulse per emitter pulse
// RL7: Four cell latches, cleared after timing pulse
// RL8: Stop pulse 2 ms after timing pulse
// RL9: Two skip timers open 10.5 ms window
// RL10: 45 ms drive check from start I/O
// RL11: Hold busy 55 ms after drive clears
// RL12: Card aligned 250 ms after card in
// RL13: Mark during late window sets late mark
// RL14: Two misses then stop after 18 lines
// RL15: Late last mark gives 19 lines
// RL16: Card-in and card-out latches from switches
// RL17: Test I/O not aligned sets card gate
// RL18: Command register loads on command steal
// RL19: Decode groups, set command-chained latch
// RL20: Eight commands coded 00 through 07
// RL21: Next command fetched after count end
// RL22: Diagnostic register loads on first execute
// RL23: Diagnostic holds replace feeder inputs
// RL24: Single shots are restartable counters
// RL25: System reset clears all latches, timers
module lcps_front #(
    parameter int STOP_CYC_P      = lcps_pkg::STOP_CYC,
    parameter int SKIP_CYC_P      = lcps_pkg::SKIP_CYC,
    parameter int DRIVE_CHK_CYC_P = lcps_pkg::DRIVE_CHK_CYC,
    parameter int HOLD_BUSY_CYC_P = lcps_pkg::HOLD_BUSY_CYC,
    parameter int ALIGN_CYC_P     = lcps_pkg::ALIGN_CYC
) (
    input  wire logic                core_clk_i,
    input  wire logic                rstn_i,
    input  wire lcps_pkg::lcps_feed_t feed_i,
    input  wire logic [7:0]          channel_out_bus_i,
    input  wire logic                cmd_steal_i,
    input  wire logic                count_end_i,
    input  wire logic                start_io_instruction_i,
    input  wire logic                test_io_not_aligned_i,
    input  wire logic                load_io_instruction_i,
    input  wire logic                first_execute_cycle_i,
    input  wire logic                drive_on_i,
    input  wire logic                gate_clear_i,
    output logic                     timing_pulse_o,
    output logic [3:0]               cell_latch_o,
    output logic                     stop_pulse_o,
    output logic                     late_mark_o,
    output logic                     feed_stop_o,
    output logic                     drive_check_o,
    output logic                     busy_o,
    output logic                     card_in_o,
    output logic                     card_out_o,
    output logic                     card_aligned_o,
    output logic                     card_gate_o,
    output logic [2:0]               cmd_o,
    output lcps_pkg::lcps_group_t    cmd_group_o,
    output logic                     cmd_chained_o,
    output logic                     fetch_next_o,
    output logic [7:0]               diag_o
);
    localparam int NIN = 8;
    // ----------------------------------------
    // Phase counter and input selection
    // ----------------------------------------
    logic [1:0]      phase_reg;
    logic [1:0]      phase_next;
    logic [NIN-1:0]  raw;
    logic [NIN-1:0]  s1_reg, s2_reg, s3_reg;
    logic [NIN-1:0]  hold_a_reg, hold_a_next, hold_b_reg, hold_b_next;
    logic [NIN-1:0]  rise;
    logic [7:0]      diag_reg, diag_next;

    // Diagnostic holds stand in for feeder lines
    always_comb begin
        raw = {feed_i.emitter, feed_i.card_in, feed_i.card_out, feed_i.cells, feed_i.line_mark};
        if (diag_reg[7]) begin
            raw = {feed_i.emitter, diag_reg[5], diag_reg[6], diag_reg[3:0], feed_i.line_mark}; // see RL23
        end
    end

    // Three-stage synchroniser
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Polarity hold pair, sampled at phase 3 and confirmed at phase 0
    always_comb begin
        phase_next  = phase_reg + 2'h1;
        hold_a_next = hold_a_reg;
        hold_b_next = hold_b_reg;
        if (phase_reg == lcps_pkg::PHASE_SAMPLE) begin
            hold_a_next = s3_reg & s2_reg; // see RL1
        end
        if (phase_reg == lcps_pkg::PHASE_RST) begin
            hold_b_next = hold_a_reg & s3_reg; // see RL4
        end
        rise = hold_a_reg & ~hold_b_reg & s3_reg & {NIN{phase_reg == lcps_pkg::PHASE_RST}}; // see RL2 RL3
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase_reg  <= 2'h0;
            hold_a_reg <= '0;
            hold_b_reg <= '0;
        end else begin
            phase_reg  <= phase_next;
            hold_a_reg <= hold_a_next;
            hold_b_reg <= hold_b_next;
        end
    end

    wire logic tp   = rise[7]; // see RL6
    wire logic mark = hold_b_reg[0] | rise[0];

    // ----------------------------------------
    // Single shots as counters
    // ----------------------------------------
    logic [lcps_pkg::TMR_W-1:0] stop_t_reg, skip1_t_reg, skip2_t_reg, drv_t_reg, busy_t_reg, algn_t_reg;
    logic [lcps_pkg::TMR_W-1:0] stop_t_next, skip1_t_next, skip2_t_next, drv_t_next, busy_t_next, algn_t_next;
    logic stop_p_reg, stop_p_next, drive_q_reg, cell_clr_reg;

    function automatic logic [lcps_pkg::TMR_W-1:0] tick(input logic fire, input int len,
                                                         input logic [lcps_pkg::TMR_W-1:0] cur);
        if (fire) tick = lcps_pkg::TMR_W'(len);
        else if (cur != '0) tick = cur - 1'b1;
        else tick = cur;
    endfunction : tick

    always_comb begin
        stop_t_next  = tick(tp, STOP_CYC_P, stop_t_reg); // see RL8 RL24
        skip1_t_next = tick(rise[7], lcps_pkg::SKIP1_CYC, skip1_t_reg); // see RL9
        skip2_t_next = tick(skip1_t_reg == lcps_pkg::TMR_W'(1), SKIP_CYC_P - lcps_pkg::SKIP1_CYC - 1, skip2_t_reg);
        drv_t_next   = tick(start_io_instruction_i, DRIVE_CHK_CYC_P, drv_t_reg); // see RL10
        busy_t_next  = tick(drive_q_reg & ~drive_on_i, HOLD_BUSY_CYC_P, busy_t_reg); // see RL11
        algn_t_next  = tick(rise[6], ALIGN_CYC_P, algn_t_reg); // see RL12
        stop_p_next  = stop_t_reg == lcps_pkg::TMR_W'(1);
        if (tp) drv_t_next = '0;
    end

    // ----------------------------------------
    // Latches
    // ----------------------------------------
    logic late_gate_reg, late_gate_next, late_reg, late_next, seen_reg, seen_next;
    logic miss1_reg, miss1_next, miss2_reg, miss2_next, skipl_reg, skipl_next;
    logic [7:0] lines_reg, lines_next;
    logic fstop_reg, fstop_next, dchk_reg, dchk_next;
    logic cin_reg, cin_next, cout_reg, cout_next, algn_reg, algn_next, gate_reg, gate_next;
    logic [3:0] cell_reg, cell_next;
    logic [2:0] cmd_reg, cmd_next;
    logic chain_reg, chain_next, fetch_reg, fetch_next;
    lcps_pkg::lcps_group_t grp_reg, grp_next;

    always_comb begin
        // Late window opens when second skip timer expires
        late_gate_next = late_gate_reg;
        if (skip2_t_reg == lcps_pkg::TMR_W'(1)) late_gate_next = 1'b1; // see RL13
        if (tp) late_gate_next = 1'b0;
        late_next = late_reg;
        if (late_gate_reg & mark) late_next = 1'b1;
        seen_next = seen_reg | mark;
        miss1_next = miss1_reg;
        miss2_next = miss2_reg;
        skipl_next = skipl_reg;
        lines_next = lines_reg;
        fstop_next = fstop_reg & ~start_io_instruction_i;
        if (tp) begin
            seen_next = 1'b0;
            late_next = 1'b0;
            if (seen_reg) begin
                miss1_next = 1'b0;
                miss2_next = 1'b0;
                skipl_next = late_reg; // see RL15
            end else if (!miss1_reg) begin
                miss1_next = 1'b1; // see RL14
            end else if (!miss2_reg) begin
                miss2_next = 1'b1;
                lines_next = skipl_reg ? lcps_pkg::SKIP_SPACES : lcps_pkg::LOCATE_SPACES;
            end else if (lines_reg != 8'h0) begin
                lines_next = lines_reg - 8'h1;
                if (lines_reg == 8'h1) fstop_next = 1'b1;
            end
        end
        // Sense cells: set from cell inputs, cleared at end of timing pulse
        cell_next = (cell_clr_reg ? 4'h0 : cell_reg) | (hold_b_reg[4:1] | rise[4:1]); // see RL7
        // Drive check error
        dchk_next = (dchk_reg & ~start_io_instruction_i) | ((drv_t_reg == lcps_pkg::TMR_W'(1)) & ~tp); // see RL10
        // Card position
        cin_next  = hold_b_reg[6]; // see RL16
        cout_next = hold_b_reg[5];
        algn_next = cin_reg & ((algn_t_reg == lcps_pkg::TMR_W'(1)) | algn_reg); // see RL12
        gate_next = (gate_reg & ~gate_clear_i) | test_io_not_aligned_i; // Set wins, see RL17
        // Command register
        cmd_next   = cmd_reg;
        chain_next = chain_reg;
        if (cmd_steal_i) begin
            cmd_next   = channel_out_bus_i[2:0]; // see RL18 RL20
            chain_next = channel_out_bus_i[2:0] inside {3'h3, 3'h4, 3'h5}; // see RL19
        end
        grp_next.count_cmd = cmd_reg >= 3'h2; // see RL19
        grp_next.read_cmd  = cmd_reg inside {3'h2, 3'h6, 3'h7};
        grp_next.eject_cmd = cmd_reg inside {3'h0, 3'h2, 3'h7};
        grp_next.diag_cmd  = cmd_reg inside {3'h3, 3'h4};
        fetch_next = count_end_i & chain_reg; // see RL21
        diag_next = (load_io_instruction_i & first_execute_cycle_i) ? channel_out_bus_i : diag_reg; // see RL22
    end

    // Register all latches; reset clears everything
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin // see RL25
            stop_t_reg <= '0; skip1_t_reg <= '0; skip2_t_reg <= '0;
            drv_t_reg <= '0; busy_t_reg <= '0; algn_t_reg <= '0;
            stop_p_reg <= 1'b0; drive_q_reg <= 1'b0; cell_clr_reg <= 1'b0;
            late_gate_reg <= 1'b0; late_reg <= 1'b0; seen_reg <= 1'b0;
            miss1_reg <= 1'b0; miss2_reg <= 1'b0; skipl_reg <= 1'b0;
            lines_reg <= 8'h0; fstop_reg <= 1'b0; dchk_reg <= 1'b0;
            cin_reg <= 1'b0; cout_reg <= 1'b0; algn_reg <= 1'b0; gate_reg <= 1'b0;
            cell_reg <= 4'h0; cmd_reg <= 3'h0; chain_reg <= 1'b0; fetch_reg <= 1'b0;
            grp_reg <= '0; diag_reg <= 8'h0;
        end else begin
            stop_t_reg <= stop_t_next; skip1_t_reg <= skip1_t_next; skip2_t_reg <= skip2_t_next;
            drv_t_reg <= drv_t_next; busy_t_reg <= busy_t_next; algn_t_reg <= algn_t_next;
            stop_p_reg <= stop_p_next; drive_q_reg <= drive_on_i; cell_clr_reg <= tp;
            late_gate_reg <= late_gate_next; late_reg <= late_next; seen_reg <= seen_next;
            miss1_reg <= miss1_next; miss2_reg <= miss2_next; skipl_reg <= skipl_next;
            lines_reg <= lines_next; fstop_reg <= fstop_next; dchk_reg <= dchk_next;
            cin_reg <= cin_next; cout_reg <= cout_next; algn_reg <= algn_next; gate_reg <= gate_next;
            cell_reg <= cell_next; cmd_reg <= cmd_next; chain_reg <= chain_next; fetch_reg <= fetch_next;
            grp_reg <= grp_next; diag_reg <= diag_next;
        end
    end

    // ----------------------------------------
    // Outputs straight from flip-flops
    // ----------------------------------------
    logic tp_reg, busy_reg;
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tp_reg   <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            tp_reg   <= tp;
            busy_reg <= drive_on_i | (busy_t_reg != '0); // see RL11
        end
    end

    assign timing_pulse_o = tp_reg;
    assign cell_latch_o   = cell_reg;
    assign stop_pulse_o   = stop_p_reg;
    assign late_mark_o    = late_reg;
    assign feed_stop_o    = fstop_reg;
    assign drive_check_o  = dchk_reg;
    assign busy_o         = busy_reg;
    assign card_in_o      = cin_reg;
    assign card_out_o     = cout_reg;
    assign card_aligned_o = algn_reg;
    assign card_gate_o    = gate_reg;
    assign cmd_o          = cmd_reg;
    assign cmd_group_o    = grp_reg;
    assign cmd_chained_o  = chain_reg;
    assign fetch_next_o   = fetch_reg;
    assign diag_o         = diag_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    cell_clear_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RL7
        cell_clr_reg && (hold_b_reg[4:1] == 4'h0) && (rise[4:1] == 4'h0) |=> cell_reg == 4'h0)
        else $error("cell latch not cleared");
    cmd_load_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RL18
        cmd_steal_i |=> cmd_reg == $past(channel_out_bus_i[2:0]))
        else $error("command register not loaded");
    diag_load_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RL22
        load_io_instruction_i && first_execute_cycle_i |=> diag_reg == $past(channel_out_bus_i))
        else $error("diagnostic register not loaded");
    gate_set_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RL17
        test_io_not_aligned_i |=> card_gate_o)
        else $error("card gate not set");
    shape_edge_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RL2
        tp |-> phase_reg == lcps_pkg::PHASE_RST)
        else $error("timing pulse off phase");
    input_persist_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RL1
        tp |-> s3_reg[7] && $past(s3_reg[7] && s2_reg[7]))
        else $error("short emitter accepted");
    tp_once_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RL6
        tp |=> !tp [*3])
        else $error("timing pulse repeated");
    stop_delay_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RL8
        tp && STOP_CYC_P < 40 |-> ##[1:41] stop_p_reg)
        else $error("stop pulse missing");
    drive_err_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RL10
        drv_t_reg == lcps_pkg::TMR_W'(1) && !tp && !start_io_instruction_i |=> dchk_reg)
        else $error("drive check not set");
endmodule : lcps_front

//--- design/lcps_pkg.sv
package lcps_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_HZ          = 10_000_000;
    localparam int STOP_US         = 2000;
    localparam int SKIP_US         = 10500;
    localparam int DRIVE_CHK_US    = 45000;
    localparam int HOLD_BUSY_US    = 55000;
    localparam int ALIGN_US        = 250000;
    localparam int STOP_CYC        = STOP_US * (CLK_HZ / 1_000_000);
    localparam int SKIP_CYC        = SKIP_US * (CLK_HZ / 1_000_000);
    localparam int DRIVE_CHK_CYC   = DRIVE_CHK_US * (CLK_HZ / 1_000_000);
    localparam int HOLD_BUSY_CYC   = HOLD_BUSY_US * (CLK_HZ / 1_000_000);
    localparam int ALIGN_CYC       = ALIGN_US * (CLK_HZ / 1_000_000);
    localparam int SKIP1_CYC       = 2;
    localparam int TMR_W           = 22;
    // ----------------------------------------
    // Counts and resets
    // ----------------------------------------
    localparam logic [7:0] LOCATE_SPACES = 8'h12;
    localparam logic [7:0] SKIP_SPACES   = 8'h13;
    localparam logic [1:0] PHASE_RST     = 2'h0;
    localparam logic [1:0] PHASE_SAMPLE  = 2'h3;
    // ----------------------------------------
    // Commands
    // ----------------------------------------
    typedef enum logic [2:0] {
        LCPS_CMD_EJECT       = 3'h0,
        LCPS_CMD_INDEX       = 3'h1,
        LCPS_CMD_READ_MARK   = 3'h2,
        LCPS_CMD_SENSE_AMP   = 3'h3,
        LCPS_CMD_SKEW        = 3'h4,
        LCPS_CMD_LOCATE_ID   = 3'h5,
        LCPS_CMD_READ_LOCATE = 3'h6,
        LCPS_CMD_READ_EJECT  = 3'h7
    } lcps_cmd_t;
    // Feeder inputs
    typedef struct packed {
        logic       emitter;
        logic       card_in;
        logic       card_out;
        logic [3:0] cells;
        logic       line_mark;
    } lcps_feed_t;
    // Command decode groups
    typedef struct packed {
        logic count_cmd;
        logic read_cmd;
        logic eject_cmd;
        logic diag_cmd;
    } lcps_group_t;
endpackage : lcps_pkg

//--- sim/lcps_feeder_model.sv
module lcps_feeder_model #(
    parameter int FIRST_CYC = 60,
    parameter int LINE_CYC  = 60,
    parameter int EARLY_CYC = 10,
    parameter int LATE_CYC  = 40
) (
    input  wire logic            core_clk_i,
    input  wire logic            rstn_i,
    input  wire logic            clutch_i,
    input  wire logic            card_in_i,
    input  wire logic            card_out_i,
    input  wire logic [3:0]      cells_i,
    input  wire logic [1:0]      mark_mode_i,
    input  wire logic            glitch_i,
    output lcps_pkg::lcps_feed_t feed_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Feed clutch motion and emitter
    // ----------------------------------------
    int         tick_reg;
    int         ph;
    logic [1:0] glitch_reg;
    // Motion counter, restarts whenever the clutch drops
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tick_reg   <= 0;
            glitch_reg <= 2'h0;
        end else begin
            tick_reg   <= !clutch_i ? 0 : (tick_reg == FIRST_CYC + LINE_CYC - 1) ? FIRST_CYC : tick_reg + 1;
            glitch_reg <= glitch_i ? 2'h1 : (glitch_reg != 2'h0) ? glitch_reg - 2'h1 : 2'h0;
        end
    end
    // Emitter, marks and switch levels toward the attachment
    always_comb begin
        ph               = tick_reg - FIRST_CYC;
        feed_o.emitter   = (clutch_i && tick_reg >= FIRST_CYC && ph < 8) || glitch_reg != 2'h0;
        feed_o.line_mark = clutch_i && tick_reg >= FIRST_CYC &&
                           ((mark_mode_i == 2'h1 && ph >= EARLY_CYC && ph < EARLY_CYC + 6) ||
                            (mark_mode_i == 2'h2 && ph >= LATE_CYC && ph < LATE_CYC + 6));
        feed_o.card_in   = card_in_i;
        feed_o.card_out  = card_out_i;
        feed_o.cells     = cells_i;
    end
endmodule : lcps_feeder_model

//--- sim/test_ledger_card_pulse_sense_control.sv
`define LCPS_CHK(got, exp, msg) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; $display("BAD %0t %s", $time, msg); end end
module test_ledger_card_pulse_sense_control;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Stimulus, instances and checks
    // ----------------------------------------
    localparam int STOP_P  = 20;
    localparam int HOLD_P  = 30;
    localparam int ALIGN_P = 40;
    localparam int CHK_P   = 40;
    logic                 core_clk_i = 1'b0;
    logic                 rstn_i     = 1'b0;
    logic [7:0]           bus        = 8'h00;
    logic                 cmd_steal  = 1'b0;
    logic                 count_end  = 1'b0;
    logic                 start_io   = 1'b0;
    logic                 test_io    = 1'b0;
    logic                 load_io    = 1'b0;
    logic                 first_exec = 1'b0;
    logic                 drive_on   = 1'b0;
    logic                 gate_clear = 1'b0;
    logic                 card_in    = 1'b0;
    logic                 card_out   = 1'b0;
    logic [3:0]           cells_in   = 4'h0;
    logic [1:0]           mark_mode  = 2'h0;
    logic                 glitch     = 1'b0;
    lcps_pkg::lcps_feed_t feed;
    lcps_pkg::lcps_group_t cmd_group;
    logic                 timing_pulse_o, stop_pulse_o, late_mark_o, feed_stop_o, drive_check_o, busy_o;
    logic                 card_in_o, card_out_o, card_aligned_o, card_gate_o, cmd_chained_o, fetch_next_o;
    logic [3:0]           cell_latch_o;
    logic [2:0]           cmd_o;
    logic [7:0]           diag_o;
    logic                 lm_prev;
    int                   miscompares = 0;
    int                   samples_checked = 0;
    int                   n;
    // Rows: bus byte, expected command and chained flag, expected command group
    logic [15:0]          cmd_rows [8] = '{16'h0002, 16'h0120, 16'h024E, 16'h0379,
                                           16'h0499, 16'h05B8, 16'h06CC, 16'h07EE};
    lcps_feeder_model #(.FIRST_CYC(30)) mdl_u (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .clutch_i(drive_on),
        .card_in_i(card_in), .card_out_i(card_out), .cells_i(cells_in), .mark_mode_i(mark_mode),
        .glitch_i(glitch), .feed_o(feed));
    lcps_front #(.STOP_CYC_P(STOP_P), .SKIP_CYC_P(20), .DRIVE_CHK_CYC_P(CHK_P), .HOLD_BUSY_CYC_P(HOLD_P),
        .ALIGN_CYC_P(ALIGN_P)) dut_u (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .feed_i(feed),
        .channel_out_bus_i(bus), .cmd_steal_i(cmd_steal), .count_end_i(count_end), .start_io_instruction_i(start_io),
        .test_io_not_aligned_i(test_io), .load_io_instruction_i(load_io), .first_execute_cycle_i(first_exec),
        .drive_on_i(drive_on), .gate_clear_i(gate_clear), .timing_pulse_o(timing_pulse_o),
        .cell_latch_o(cell_latch_o), .stop_pulse_o(stop_pulse_o), .late_mark_o(late_mark_o),
        .feed_stop_o(feed_stop_o), .drive_check_o(drive_check_o), .busy_o(busy_o), .card_in_o(card_in_o),
        .card_out_o(card_out_o), .card_aligned_o(card_aligned_o), .card_gate_o(card_gate_o), .cmd_o(cmd_o),
        .cmd_group_o(cmd_group), .cmd_chained_o(cmd_chained_o), .fetch_next_o(fetch_next_o), .diag_o(diag_o));
    // Clock, 100 ns period
    always #50 core_clk_i = ~core_clk_i;
    task complete_run;
        $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : complete_run
    task cyc(input int k);
        repeat (k) @(negedge core_clk_i);
    endtask : cyc
    task set_strobe(input int which, input logic v);
        case (which)
            0: cmd_steal <= v;
            1: start_io <= v;
            2: test_io <= v;
            3: gate_clear <= v;
            4: begin
                load_io    <= v;
                first_exec <= v;
            end
            5: count_end <= v;
            default: glitch <= v;
        endcase
    endtask : set_strobe
    task pulse_in(input int which);
        @(posedge core_clk_i);
        set_strobe(which, 1'b1);
        @(posedge core_clk_i);
        set_strobe(which, 1'b0);
    endtask : pulse_in
    task wait_tp;
        for (int i = 0; i < 300; i++) begin
            @(negedge core_clk_i);
            if (timing_pulse_o === 1'b1) return;
            lm_prev = late_mark_o;
        end
        miscompares++;
        complete_run();
    endtask : wait_tp
    // One feed: a mark on the first line only, then misses until the feed stops
    task run_feed(input logic late);
        pulse_in(1);
        @(posedge core_clk_i);
        drive_on <= 1'b1;
        for (n = 1; n <= 30; n++) begin
            wait_tp();
            if (n == 2) `LCPS_CHK(lm_prev, late, "late mark flag");
            @(posedge core_clk_i);
            mark_mode <= (n == 1) ? (late ? 2'h2 : 2'h1) : 2'h0;
            cells_in  <= (n == 1) ? 4'hA : 4'h0;
            for (int k = 1; k <= STOP_P + 4 && n == 1; k++) begin
                @(negedge core_clk_i);
                `LCPS_CHK(stop_pulse_o, 1'(k == STOP_P), "stop pulse timing");
                if (k == 15) `LCPS_CHK(cell_latch_o, 4'hA, "cell latch set");
            end
            @(posedge core_clk_i);
            cells_in <= 4'h0;
            cyc(3);
            if (n == 2) `LCPS_CHK(cell_latch_o, 4'h0, "cell latch clear");
            if (feed_stop_o === 1'b1) break;
        end
        `LCPS_CHK(n, 22 + int'(late), "lines fed before stop");
        @(posedge core_clk_i);
        drive_on <= 1'b0;
    endtask : run_feed
    // Main sequence
    initial begin
        cyc(4);
        `LCPS_CHK(|{timing_pulse_o, cell_latch_o, stop_pulse_o, late_mark_o, feed_stop_o, drive_check_o, busy_o,
            card_in_o, card_out_o, card_aligned_o, card_gate_o, cmd_o, cmd_group, cmd_chained_o, fetch_next_o,
            diag_o}, 1'b0, "outputs in reset");
        @(posedge core_clk_i);
        rstn_i <= 1'b1;
        cyc(2);
        foreach (cmd_rows[r]) begin
            @(posedge core_clk_i);
            bus <= cmd_rows[r][15:8];
            pulse_in(0);
            cyc(2);
            `LCPS_CHK(cmd_o, cmd_rows[r][7:5], "command register");
            `LCPS_CHK(cmd_chained_o, cmd_rows[r][4], "chained flag");
            `LCPS_CHK(cmd_group, cmd_rows[r][3:0], "command group");
        end
        // Count end with and without a chained command
        pulse_in(5);
        cyc(1);
        `LCPS_CHK(fetch_next_o, 1'b0, "fetch without chain");
        @(posedge core_clk_i);
        bus <= 8'h05;
        pulse_in(0);
        pulse_in(5);
        cyc(1);
        `LCPS_CHK(fetch_next_o, 1'b1, "next command fetch");
        cyc(1);
        `LCPS_CHK(fetch_next_o, 1'b0, "fetch pulse length");
        pulse_in(2);
        cyc(2);
        `LCPS_CHK(card_gate_o, 1'b1, "card gate set");
        pulse_in(3);
        cyc(2);
        `LCPS_CHK(card_gate_o, 1'b0, "card gate clear");
        @(posedge core_clk_i);
        card_in  <= 1'b1;
        card_out <= 1'b1;
        for (int i = 0; i < 20 && card_in_o !== 1'b1; i++) cyc(1);
        `LCPS_CHK(card_in_o, 1'b1, "card in latch");
        cyc(ALIGN_P - 4);
        `LCPS_CHK(card_aligned_o, 1'b0, "aligned too early");
        cyc(8);
        `LCPS_CHK(card_aligned_o, 1'b1, "aligned late");
        `LCPS_CHK(card_out_o, 1'b1, "card out latch");
        @(posedge core_clk_i);
        card_in  <= 1'b0;
        card_out <= 1'b0;
        bus      <= 8'hA5;
        pulse_in(4);
        cyc(12);
        `LCPS_CHK(diag_o, 8'hA5, "diagnostic register");
        `LCPS_CHK(card_in_o, 1'b1, "diagnostic card in");
        `LCPS_CHK(cell_latch_o, 4'h5, "diagnostic cells");
        @(posedge core_clk_i);
        bus <= 8'h00;
        pulse_in(4);
        cyc(12);
        `LCPS_CHK(card_in_o, 1'b0, "diagnostic release");
        @(posedge core_clk_i);
        card_in <= 1'b1;
        pulse_in(1);
        cyc(CHK_P - 4);
        `LCPS_CHK(drive_check_o, 1'b0, "drive check early");
        cyc(10);
        `LCPS_CHK(drive_check_o, 1'b1, "drive check missing");
        run_feed(1'b0);
        cyc(HOLD_P - 5);
        `LCPS_CHK(busy_o, 1'b1, "hold busy short");
        cyc(15);
        `LCPS_CHK(busy_o, 1'b0, "hold busy long");
        `LCPS_CHK(drive_check_o, 1'b0, "drive check after feed");
        run_feed(1'b1);
        cyc(HOLD_P + 10);
        pulse_in(6);
        repeat (30) begin
            cyc(1);
            `LCPS_CHK(timing_pulse_o, 1'b0, "short emitter accepted");
        end
        complete_run();
    end
endmodule : test_ledger_card_pulse_sense_control
